// ===== core/tdh_map.svh
// register map, field positions and line constants of the data link control block
`ifndef TDH_MAP_SVH
`define TDH_MAP_SVH

// ******************************
// register indices (byte address = index * 4)
// ******************************
`define TDH_IDX_CONTROL 16'h0113
`define TDH_IDX_STATUS 16'h011f
`define TDH_CONTROL_RESET 8'h00

// ******************************
// control fields
// ******************************
`define TDH_BIT_LOOP_CARRIER 7
`define TDH_BIT_ABORT_DISABLE 6
`define TDH_BIT_RX_FCS_DISABLE 5
`define TDH_BIT_RX_DISCARD 4
`define TDH_BIT_TX_ABORT 3
`define TDH_BIT_TX_IDLE 2
`define TDH_BIT_TX_FCS 1
`define TDH_BIT_MODE 0

// ******************************
// line patterns
// ******************************
`define TDH_FLAG 8'h7e
`define TDH_ABORT_BYTE 8'hfe
`define TDH_BOS_LEAD 8'hff
`define TDH_CRC_INIT 16'hffff
`define TDH_CRC_POLY 16'h8408
`define TDH_CRC_GOOD 16'hf0b8
`define TDH_STUFF_RUN 3'h5
`define TDH_ABORT_RUN 4'h7
`define TDH_MIN_FRAME 8'h03

`endif

// ===== core/tdh_pkg.sv
// types and check sequence helper of the data link control block
`include "tdh_map.svh"
package tdh_pkg;

  typedef enum logic [2:0] {
    S_IDLE, S_MDATA, S_F1, S_F2, S_CLOSE, S_AB, S_BOS
  } tdh_tx_state_t;

  function automatic logic [15:0] tdh_crc_upd(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      r = (r[0] ^ d[i]) ? ((r >> 1) ^ `TDH_CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

endpackage

// ===== core/tdh_control.sv
// data link hdlc controller one: control register, transmit and receive paths
// Behaviour
// - bit 7 selects loop carrier data link format
// - auto abort on switch to bit-oriented
// - bit 6 set: switch without abort
// - bit 5 clear: check receive FCS
// - bit 3 set: send continuous ones
// - bit 2 set: send only flag octets
// - idle line filled with flag octets in message mode
// - idle bit ignored in bit-oriented mode
// - bit 0 selects bit or message oriented
// - bit 1 appends FCS in message mode
`timescale 1ns/100ps
`include "tdh_map.svh"
module tdh_control (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // avalon-mm slave
  input wire logic [15:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // framing format
  output logic loop_carrier_datalink_enable,
  output logic superframe_bits_select,
  // transmit user side
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  input wire logic tx_last,
  output logic tx_ready,
  input wire logic [5:0] tx_bos_code,
  // transmit line
  input wire logic link_tx_tick,
  output logic link_tx_bit,
  // receive line
  input wire logic link_rx_tick,
  input wire logic link_rx_bit,
  // receive user side
  output logic [7:0] rx_data,
  output logic rx_data_valid,
  output logic rx_frame_end,
  output logic rx_frame_good,
  output logic rx_frame_discard,
  output logic [5:0] rx_bos_code,
  output logic rx_bos_valid
);
  import tdh_pkg::*;

  // ******************************
  // reset release
  // ******************************
  logic rst_meta, rst_n;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // ******************************
  // register bus
  // ******************************
  logic [7:0] ctrl, next_ctrl;
  logic ack, next_ack;
  logic [31:0] next_rdata;
  logic [3:0] status;
  logic hit_ctrl, hit_stat, req;
  assign req = avs_read | avs_write;
  assign hit_ctrl = avs_address == 16'(`TDH_IDX_CONTROL << 2);
  assign hit_stat = avs_address == 16'(`TDH_IDX_STATUS << 2);
  assign avs_waitrequest = req & ~ack;

  always_comb begin
    next_ack = req & ~ack;
    next_ctrl = ctrl;
    next_rdata = avs_readdata;
    if (avs_write && ack && hit_ctrl) begin
      next_ctrl = avs_writedata[7:0];
    end
    if (avs_read && !ack) begin
      next_rdata = hit_ctrl ? {24'h0, ctrl} : hit_stat ? {28'h0, status} : 32'h0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack <= 1'b0;
      ctrl <= `TDH_CONTROL_RESET;
      avs_readdata <= 32'h0;
    end else begin
      ack <= next_ack;
      ctrl <= next_ctrl;
      avs_readdata <= next_rdata;
    end
  end

  assign loop_carrier_datalink_enable = ctrl[`TDH_BIT_LOOP_CARRIER];
  assign superframe_bits_select = ~ctrl[`TDH_BIT_LOOP_CARRIER];

  // ******************************
  // transmit path
  // ******************************
  tdh_tx_state_t tx_state, next_tx_state;
  logic [7:0] sh, next_sh, cur_sh;
  logic [3:0] cnt, next_cnt, cur_cnt;
  logic [2:0] ones, next_ones;
  logic stuff, next_stuff, cur_stuff;
  logic [15:0] tcrc, next_tcrc;
  logic half, next_half, next_bit, tx_load;
  logic in_mos;
  assign in_mos = tx_state == S_MDATA || tx_state == S_F1 || tx_state == S_F2;
  assign tx_ready = tx_load;

  always_comb begin
    next_tx_state = tx_state;
    next_sh = sh;
    next_cnt = cnt;
    next_ones = ones;
    next_stuff = stuff;
    next_tcrc = tcrc;
    next_half = half;
    next_bit = link_tx_bit;
    tx_load = 1'b0;
    cur_sh = sh;
    cur_cnt = cnt;
    cur_stuff = stuff;
    if (link_tx_tick) begin
      if (ctrl[`TDH_BIT_TX_ABORT]) begin
        next_bit = 1'b1;
        next_cnt = 4'h0;
        next_ones = 3'h0;
        next_tx_state = S_IDLE;
      end else begin
        if (cnt == 4'h0) begin
          cur_cnt = 4'h8;
          cur_stuff = 1'b0;
          cur_sh = `TDH_FLAG;
          if (!ctrl[`TDH_BIT_MODE]) begin
            if (in_mos && !ctrl[`TDH_BIT_ABORT_DISABLE]) begin
              cur_sh = `TDH_ABORT_BYTE;
              next_tx_state = S_AB;
            end else if (in_mos) begin
              cur_sh = `TDH_BOS_LEAD;
              next_half = 1'b1;
              next_tx_state = S_BOS;
            end else begin
              cur_sh = half ? {1'b0, tx_bos_code, 1'b0} : `TDH_BOS_LEAD;
              next_half = ~half;
              next_tx_state = S_BOS;
            end
          end else if (ctrl[`TDH_BIT_TX_IDLE]) begin
            next_tx_state = S_IDLE;
          end else begin
            unique case (tx_state)
              S_IDLE, S_MDATA: begin
                if (tx_valid) begin
                  cur_sh = tx_data;
                  cur_stuff = 1'b1;
                  tx_load = 1'b1;
                  next_tcrc = tdh_crc_upd(tx_state == S_IDLE ? `TDH_CRC_INIT : tcrc, tx_data);
                  next_tx_state = tx_last ? (ctrl[`TDH_BIT_TX_FCS] ? S_F1 : S_CLOSE) : S_MDATA;
                end else if (tx_state == S_MDATA) begin
                  cur_sh = `TDH_ABORT_BYTE;
                  next_tx_state = S_IDLE;
                end
              end
              S_F1: begin
                cur_sh = ~tcrc[7:0];
                cur_stuff = 1'b1;
                next_tx_state = S_F2;
              end
              S_F2: begin
                cur_sh = ~tcrc[15:8];
                cur_stuff = 1'b1;
                next_tx_state = S_CLOSE;
              end
              S_CLOSE, S_AB, S_BOS: begin
                next_tx_state = S_IDLE;
              end
            endcase
          end
        end
        next_stuff = cur_stuff;
        if (cur_stuff && ones == `TDH_STUFF_RUN) begin
          next_bit = 1'b0;
          next_ones = 3'h0;
          next_sh = cur_sh;
          next_cnt = cur_cnt;
        end else begin
          next_bit = cur_sh[0];
          next_sh = {1'b0, cur_sh[7:1]};
          next_cnt = 4'(cur_cnt - 4'h1);
          next_ones = (cur_stuff && cur_sh[0]) ? 3'(ones + 3'h1) : 3'h0;
        end
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_state <= S_IDLE;
      sh <= 8'h0;
      cnt <= 4'h0;
      ones <= 3'h0;
      stuff <= 1'b0;
      tcrc <= `TDH_CRC_INIT;
      half <= 1'b0;
      link_tx_bit <= 1'b1;
    end else begin
      tx_state <= next_tx_state;
      sh <= next_sh;
      cnt <= next_cnt;
      ones <= next_ones;
      stuff <= next_stuff;
      tcrc <= next_tcrc;
      half <= next_half;
      link_tx_bit <= next_bit;
    end
  end

  // ******************************
  // receive path
  // ******************************
  logic [15:0] win, next_win, rcrc, next_rcrc, prev_crc, next_prev_crc;
  logic [3:0] rones, next_rones;
  logic [7:0] rsr, next_rsr, nbytes, next_nbytes, prev_len, next_prev_len, next_rx_data;
  logic [2:0] bcnt, next_bcnt;
  logic in_frame, next_in_frame, prev_bos_ok, next_prev_bos_ok;
  logic [5:0] next_bos_code;
  logic next_dv, next_end, next_good, next_disc, next_bos_v, fcs_ok, dup, end_c;
  logic bos_hit, fcs_err, next_fcs_err;
  // last two bytes of a frame: its check sequence, stands for its content
  logic [15:0] last2, next_last2;
  assign status = {tx_state != S_IDLE, rx_frame_discard, fcs_err, in_frame};

  always_comb begin
    next_win = win;
    next_rones = rones;
    next_rsr = rsr;
    next_bcnt = bcnt;
    next_rcrc = rcrc;
    next_nbytes = nbytes;
    next_in_frame = in_frame;
    next_prev_crc = prev_crc;
    next_prev_len = prev_len;
    next_prev_bos_ok = prev_bos_ok;
    next_bos_code = rx_bos_code;
    next_rx_data = rx_data;
    next_fcs_err = fcs_err;
    next_last2 = last2;
    next_dv = 1'b0;
    next_end = 1'b0;
    next_good = rx_frame_good;
    next_disc = rx_frame_discard;
    next_bos_v = 1'b0;
    end_c = 1'b0;
    bos_hit = 1'b0;
    fcs_ok = ctrl[`TDH_BIT_RX_FCS_DISABLE] || rcrc == `TDH_CRC_GOOD;
    dup = ctrl[`TDH_BIT_RX_DISCARD] && last2 == prev_crc && nbytes == prev_len;
    if (link_rx_tick) begin
      next_win = {link_rx_bit, win[15:1]};
      next_rones = link_rx_bit ? (rones == `TDH_ABORT_RUN ? rones : 4'(rones + 4'h1)) : 4'h0;
      if (next_win[15:8] == `TDH_FLAG) begin
        if (in_frame && nbytes >= `TDH_MIN_FRAME) begin
          end_c = 1'b1;
          next_end = 1'b1;
          next_good = fcs_ok && !dup;
          next_disc = dup;
          next_fcs_err = !fcs_ok;
          if (fcs_ok && !dup) begin
            next_prev_crc = last2;
            next_prev_len = nbytes;
          end
        end
        next_in_frame = 1'b1;
        next_bcnt = 3'h0;
        next_nbytes = 8'h0;
        next_rcrc = `TDH_CRC_INIT;
      end else if (next_rones == `TDH_ABORT_RUN) begin
        next_in_frame = 1'b0;
      end else if (!link_rx_bit && rones == 4'(`TDH_STUFF_RUN)) begin
        next_bcnt = bcnt;
      end else if (in_frame) begin
        next_rsr = {link_rx_bit, rsr[7:1]};
        next_bcnt = 3'(bcnt + 3'h1);
        if (bcnt == 3'h7) begin
          next_rx_data = next_rsr;
          next_last2 = {next_rsr, last2[15:8]};
          next_dv = 1'b1;
          next_rcrc = tdh_crc_upd(rcrc, next_rsr);
          next_nbytes = (nbytes == 8'hff) ? nbytes : 8'(nbytes + 8'h1);
        end
      end
      if (next_win[7:0] == `TDH_BOS_LEAD && !next_win[15] && !next_win[8]) begin
        bos_hit = 1'b1;
        next_bos_code = next_win[14:9];
        next_prev_bos_ok = 1'b1;
        next_bos_v = !(ctrl[`TDH_BIT_RX_DISCARD] && prev_bos_ok && next_win[14:9] == rx_bos_code);
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      win <= 16'h0;
      rones <= 4'h0;
      rsr <= 8'h0;
      bcnt <= 3'h0;
      rcrc <= `TDH_CRC_INIT;
      nbytes <= 8'h0;
      in_frame <= 1'b0;
      prev_crc <= 16'h0;
      prev_len <= 8'h0;
      prev_bos_ok <= 1'b0;
      fcs_err <= 1'b0;
      last2 <= 16'h0;
      rx_data <= 8'h0;
      rx_data_valid <= 1'b0;
      rx_frame_end <= 1'b0;
      rx_frame_good <= 1'b0;
      rx_frame_discard <= 1'b0;
      rx_bos_code <= 6'h0;
      rx_bos_valid <= 1'b0;
    end else begin
      win <= next_win;
      rones <= next_rones;
      rsr <= next_rsr;
      bcnt <= next_bcnt;
      rcrc <= next_rcrc;
      nbytes <= next_nbytes;
      in_frame <= next_in_frame;
      prev_crc <= next_prev_crc;
      prev_len <= next_prev_len;
      prev_bos_ok <= next_prev_bos_ok;
      fcs_err <= next_fcs_err;
      last2 <= next_last2;
      rx_data <= next_rx_data;
      rx_data_valid <= next_dv;
      rx_frame_end <= next_end;
      rx_frame_good <= next_good;
      rx_frame_discard <= next_disc;
      rx_bos_code <= next_bos_code;
      rx_bos_valid <= next_bos_v;
    end
  end

  // ******************************
  // checks
  // ******************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  logic load_c;
  assign load_c = link_tx_tick && cnt == 4'h0 && !ctrl[`TDH_BIT_TX_ABORT];

  a_abort_ones: assert property (link_tx_tick && ctrl[`TDH_BIT_TX_ABORT] |=> link_tx_bit)
    else $error("forced abort did not send a one");
  a_auto_abort: assert property (load_c && !ctrl[`TDH_BIT_MODE] && in_mos && !ctrl[`TDH_BIT_ABORT_DISABLE]
    |=> tx_state == S_AB && !link_tx_bit && sh == 8'h7f)
    else $error("auto abort byte not sent on switch");
  a_abort_skip: assert property (load_c && !ctrl[`TDH_BIT_MODE] && in_mos && ctrl[`TDH_BIT_ABORT_DISABLE]
    |=> tx_state == S_BOS && link_tx_bit)
    else $error("abort sent although disabled");
  a_idle_force: assert property (ctrl[`TDH_BIT_MODE] && ctrl[`TDH_BIT_TX_IDLE] |-> !tx_ready)
    else $error("frame data taken while idle forced");
  a_bos_ignore: assert property (load_c && !ctrl[`TDH_BIT_MODE] && ctrl[`TDH_BIT_TX_IDLE] |=> tx_state != S_IDLE)
    else $error("idle bit acted in bit-oriented mode");
  a_fcs_append: assert property (tx_ready && tx_last |=> tx_state == (ctrl[`TDH_BIT_TX_FCS] ? S_F1 : S_CLOSE))
    else $error("check sequence append wrong");
  a_zero_insert: assert property (link_tx_tick && !ctrl[`TDH_BIT_TX_ABORT] && (cnt == 4'h0 ? 1'b0 : stuff)
    && ones == `TDH_STUFF_RUN |=> !link_tx_bit)
    else $error("zero not inserted after five ones");
  a_fcs_verify: assert property (end_c && !ctrl[`TDH_BIT_RX_FCS_DISABLE] && rcrc != `TDH_CRC_GOOD
    |=> rx_frame_end && !rx_frame_good)
    else $error("bad check sequence accepted");
  a_dup_drop: assert property (end_c && dup |=> rx_frame_end && rx_frame_discard && !rx_frame_good)
    else $error("duplicate frame kept");
  a_ctrl_write: assert property (avs_write && !avs_waitrequest && hit_ctrl
    |=> ctrl == $past(avs_writedata[7:0]) && superframe_bits_select == !ctrl[7])
    else $error("control write lost");
  a_bus_wait: assert property (req && !ack |-> avs_waitrequest ##1 !avs_waitrequest || !req)
    else $error("bus answer late");

  c_frame_sent: cover property (tx_ready && tx_last ##[1:300] tx_state == S_CLOSE);
  c_auto_abort: cover property (tx_state == S_MDATA ##1 tx_state == S_AB);
  c_rx_good: cover property (rx_frame_end && rx_frame_good);
  c_rx_bos: cover property (rx_bos_valid || bos_hit);
endmodule

// ===== tb/tdh_remote.sv
// remote terminal model: line bit clocks, receive bit source, transmit bit capture
`timescale 1ns/100ps
module tdh_remote (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // line toward the block
  output logic link_tx_tick,
  output logic link_rx_tick,
  output logic link_rx_bit,
  input wire logic link_tx_bit,
  // recent transmit bits, newest at the top
  output logic [23:0] line_seen
);
  logic [1:0] div;
  logic cap;
  logic q[$];
  // ******************************
  // bit timing and line
  // ******************************
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      div <= 2'h0;
      link_tx_tick <= 1'b0;
      link_rx_tick <= 1'b0;
      link_rx_bit <= 1'b0;
      cap <= 1'b0;
      line_seen <= 24'h000000;
    end else begin
      div <= div + 2'h1;
      link_tx_tick <= (div == 2'h3);
      cap <= link_tx_tick;
      link_rx_tick <= 1'b0;
      // idle line never keeps its last value
      link_rx_bit <= ~link_rx_bit;
      if (div == 2'h3 && q.size() > 0) begin
        link_rx_tick <= 1'b1;
        link_rx_bit <= q.pop_front();
      end
      if (cap)
        line_seen <= {link_tx_bit, line_seen[23:1]};
    end
  end
endmodule

// ===== tb/tb_tdh_control.sv
// self-checking bench of the data link control block
`timescale 1ns/100ps
`include "tdh_map.svh"
module tb_tdh_control;
  logic ref_clk, reset_n, avs_read, avs_write, avs_waitrequest;
  logic [15:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic loop_carrier_datalink_enable, superframe_bits_select;
  logic [7:0] tx_data, rx_data;
  logic tx_valid, tx_last, tx_ready, link_tx_tick, link_tx_bit, link_rx_tick, link_rx_bit;
  logic [5:0] tx_bos_code, rx_bos_code;
  logic rx_data_valid, rx_frame_end, rx_frame_good, rx_frame_discard, rx_bos_valid;
  logic [23:0] line_seen;
  int err_count, n_tests, cyc;
  localparam logic [15:0] CTRL_A = 16'h044c;

  tdh_control tdh_control_i (.*);
  tdh_remote tdh_remote_i (.*);

  // ******************************
  // clock, timeout, shared tasks
  // ******************************
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 40000) begin
      err_count++;
      final_report();
    end
  end

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic wr, input logic [15:0] a, input logic [31:0] d);
    logic w;
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(negedge ref_clk);
      w = avs_waitrequest;
      rd = avs_readdata;
      @(posedge ref_clk);
    end while (w !== 1'b0);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  // 0 flags, 1 bit-oriented stream, 2 all ones, 3 other
  function automatic int kind(input logic [23:0] s);
    int k;
    k = 3;
    if (s == 24'hffffff)
      return 2;
    for (int i = 0; i < 17; i++) begin
      if (s[i +: 8] == 8'hff)
        return 1;
    end
    for (int i = 0; i < 8; i++) begin
      if (s[23:16] == s[15:8] && s[15:8] == 8'(({`TDH_FLAG, `TDH_FLAG} >> i)))
        k = 0;
    end
    return k;
  endfunction

  // ******************************
  // scenarios
  // ******************************
  task automatic t_regs();
    bus(0, CTRL_A, 0);
    check(rd, {24'h0, `TDH_CONTROL_RESET});
    check({loop_carrier_datalink_enable, superframe_bits_select}, 2'b01);
    bus(1, CTRL_A, 32'h000000b6);
    bus(0, CTRL_A, 0);
    check(rd, 32'h000000b6);
    check({loop_carrier_datalink_enable, superframe_bits_select}, 2'b10);
    bus(1, 16'h0400, 32'h000000ff);
    bus(0, 16'h0400, 0);
    check(rd, 32'h0);
    bus(1, CTRL_A, 32'h0);
    $display("test regs done");
  endtask

  task automatic t_tx();
    logic [7:0] ctl[5] = '{8'h01, 8'h05, 8'h00, 8'h04, 8'h09};
    int exk[5] = '{0, 0, 1, 1, 2};
    int n;
    for (int i = 0; i < 5; i++) begin
      bus(1, CTRL_A, {24'h0, ctl[i]});
      tx_valid <= 1'b1;
      n = 0;
      repeat (400) begin
        @(posedge ref_clk);
        n += (tx_ready === 1'b1);
      end
      check(n > 0, i == 0);
      tx_valid <= 1'b0;
      repeat (400) @(posedge ref_clk);
      check(kind(line_seen), exk[i]);
    end
    $display("test transmit done");
  endtask

  // abort shows as a run of exactly 7 ones, or 15 when a lead byte follows
  task automatic t_abort();
    logic [7:0] sw[2] = '{8'h00, 8'h40};
    int run;
    logic seen;
    for (int i = 0; i < 2; i++) begin
      tx_last <= 1'b0;
      tx_valid <= 1'b1;
      bus(1, CTRL_A, 32'h00000001);
      repeat (200) @(posedge ref_clk);
      bus(1, CTRL_A, {24'h0, sw[i]});
      run = 0;
      seen = 1'b0;
      repeat (400) begin
        @(negedge ref_clk);
        if (link_tx_tick === 1'b1) begin
          if (link_tx_bit === 1'b1) begin
            run++;
          end else begin
            seen |= (run == 7 || run >= 15);
            run = 0;
          end
        end
      end
      check(seen, i == 0);
    end
    tx_valid <= 1'b0;
    tx_last <= 1'b1;
    $display("test abort switch done");
  endtask

  task automatic put_byte(input logic [7:0] b, input logic stuff, inout int ones);
    for (int k = 0; k < 8; k++) begin
      tdh_remote_i.q.push_back(b[k]);
      ones = b[k] ? ones + 1 : 0;
      if (stuff && ones == 5) begin
        tdh_remote_i.q.push_back(1'b0);
        ones = 0;
      end
    end
  endtask

  task automatic t_rx();
    logic [7:0] ctl[6] = '{8'h00, 8'h00, 8'h20, 8'h10, 8'h10, 8'h00};
    logic [7:0] b0[6] = '{8'h12, 8'h12, 8'h13, 8'hc5, 8'hc5, 8'hc5};
    logic bad[6] = '{0, 1, 1, 0, 0, 0};
    logic [1:0] exp[6] = '{2'b10, 2'b00, 2'b10, 2'b10, 2'b01, 2'b10};
    logic [7:0] f[5];
    logic [15:0] c;
    int ones, n, w;
    for (int i = 0; i < 6; i++) begin
      bus(1, CTRL_A, {24'h0, ctl[i]});
      f = '{b0[i], 8'h34, 8'h56, 8'h00, 8'h00};
      c = `TDH_CRC_INIT;
      for (int j = 0; j < 24; j++)
        c = (c[0] ^ f[j / 8][j % 8]) ? ((c >> 1) ^ `TDH_CRC_POLY) : (c >> 1);
      c = ~c ^ {15'h0, bad[i]};
      f[3] = c[7:0];
      f[4] = c[15:8];
      ones = 0;
      put_byte(`TDH_FLAG, 0, ones);
      for (int j = 0; j < 5; j++)
        put_byte(f[j], 1, ones);
      put_byte(`TDH_FLAG, 0, ones);
      n = 0;
      w = 0;
      while (rx_frame_end !== 1'b1 && w < 1000) begin
        @(posedge ref_clk);
        n += (rx_data_valid === 1'b1);
        w++;
      end
      check(n, 5);
      check({rx_frame_good, rx_frame_discard}, exp[i]);
    end
    $display("test receive done");
  endtask

  // ******************************
  // main sequence
  // ******************************
  initial begin
    reset_n = 1'b0;
    avs_address = 16'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    tx_data = 8'h5a;
    tx_valid = 1'b0;
    tx_last = 1'b1;
    tx_bos_code = 6'h15;
    repeat (4) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    t_regs();
    t_tx();
    t_abort();
    t_rx();
    final_report();
  end
endmodule
